//--- ais_host_model.sv
/*
  Host model: register accesses and source register read strobes.
  Assumes one-cycle strobes taken on the rising edge of clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ais_params.svh"
module ais_host_model
(
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  output logic [3:0] det_src_rd,
  output logic [2:0] axis_msb_rd,
  output logic buf_status_rd
);
  initial
  begin
    {reg_addr, reg_wdata} = 16'h0000;
    {reg_wr, reg_rd, buf_status_rd, axis_msb_rd, det_src_rd} = 10'h000;
  end

  // Access with a random delay before it; returns read data
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    repeat ($urandom_range(2, 0)) @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge clk_sys);
    #1;
    {reg_wr, reg_rd} = 2'b00;
    reg_addr = ~a;
    reg_wdata = ~d;
    @(posedge clk_sys);
    #1;
    q = reg_rdata;
  endtask

  task automatic poll_mode(output logic [7:0] q);
    acc(1'b0, `AIS_SYSTEM_MODE_STATE_OFS, 8'h00, q);
  endtask

  // Bits: [3:0] detector source, [6:4] axis bytes, [7] buffer status
  task automatic strobe(input logic [7:0] m);
    @(posedge clk_sys);
    #1;
    {buf_status_rd, axis_msb_rd, det_src_rd} = m;
    @(posedge clk_sys);
    #1;
    {buf_status_rd, axis_msb_rd, det_src_rd} = 8'h00;
  endtask
endmodule
`default_nettype wire

//--- ais_int_status.sv
/*
  Interrupt source, system mode and buffer trigger registers.
  Assumes a register engine behind the serial port gives one-cycle
  read and write strobes, and the detectors give level interrupts.
*/
// What this block does
// R01: Trigger select bits 5..2 pick detectors that trigger the buffer; reset 0.
// R02: Trigger status bits set only on a detector's rising edge.
// R03: Trigger status bit clears when that detector's source register is read.
// R04: Selected detector edge triggers buffer one cycle later; status 0 means no edge yet.
// R05: Mode field bits 1..0 read 00 standby, 01 wake, 10 sleep.
// R06: Host polls the mode register to track auto sleep and wake.
// R07: Gate error bit 7 sets on detection, clears when the buffer empties.
// R08: Bits 6..2 count sample periods since gate error; zero when cleared.
// R09: Source bit reads 1 once its function asserted, 0 otherwise.
// R10: Source bits set on rising edges, cleared by their own source read.
// R11: New-data bit clears only after all three axis MSB bytes are read.
// R12: No activity beyond the limit moves wake to sleep, low rate, bit 7.
// R13: Wake event moves sleep to wake, high rate, sets bit 7.
// R14: Reading the mode register clears source bit 7.
// R15: Buffer bit 6 sets on overflow or watermark if enabled; status read clears.
// R16: Buffer bit sets again on next sample while the condition holds.
// R17: Transient bit 5 latches its event flag's rising edge if enabled; transient source read clears.
`timescale 1ns/1ps
`default_nettype none
`include "ais_params.svh"
module ais_int_status
  import ais_pkg::*;
#(
  parameter int CNT_W = 8
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] det_irq,
  input wire logic [3:0] det_int_en,
  input wire logic [3:0] det_src_rd,
  input wire logic [3:0] wake_sel,
  input wire logic active_en,
  input wire logic autosleep_en,
  input wire logic [CNT_W-1:0] inactivity_limit,
  input wire logic odr_tick,
  input wire logic axes_new_data_flag,
  input wire logic drdy_int_en,
  input wire logic [2:0] axis_msb_rd,
  input wire logic buf_ovf,
  input wire logic buf_wmrk,
  input wire logic buf_int_en,
  input wire logic buf_sample_push,
  input wire logic buf_status_rd,
  input wire logic buf_empty,
  input wire logic gate_err_det,
  output logic buffer_trigger,
  output logic high_rate_sel,
  output logic [1:0] sys_mode
);
  ais_mode_if mif ();

  logic [3:0] sel_r, sel_nxt;
  logic [3:0] tstat_r, tstat_nxt;
  logic [3:0] prev_r;
  logic [3:0] rise;
  logic [3:0] det_src_nxt;
  logic [7:0] src_r, src_nxt;
  logic [2:0] msb_r, msb_nxt;
  logic nd_prev_r;
  logic bc_prev_r;
  logic gerr_r, gerr_nxt;
  logic [4:0] fgt_r, fgt_nxt;
  logic trig_r, trig_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic nd_rise;
  logic buf_cond;
  logic buf_set;
  logic trig_wr;
  logic system_mode_state_rd;

  assign trig_wr = reg_wr && (reg_addr == `AIS_TRIG_OFS);
  assign system_mode_state_rd = reg_rd && (reg_addr == `AIS_SYSTEM_MODE_STATE_OFS);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_det
      // R02: edge, not level
      assign rise[gi] = det_irq[gi] && !prev_r[gi];
      // R03: set wins over read clear
      assign tstat_nxt[gi] = (rise[gi] && sel_r[gi]) || (tstat_r[gi] && !det_src_rd[gi]);
      // R10: per function edge latch
      // R17: transient bit, enabled only
      assign det_src_nxt[gi] = (rise[gi] && det_int_en[gi])
                             || (src_r[`AIS_SRC_DET_LSB + gi] && !det_src_rd[gi]);
    end
  endgenerate

  assign nd_rise = axes_new_data_flag && drdy_int_en && !nd_prev_r;
  assign buf_cond = buf_int_en && (buf_ovf || buf_wmrk);
  // R16: re-arm on each new sample
  assign buf_set = buf_cond && (!bc_prev_r || buf_sample_push);

  always_comb
  begin
    sel_nxt = sel_r;
    // R01: software selects triggers
    if (trig_wr)
      sel_nxt = reg_wdata[`AIS_TRIG_LSB +: 4];
    // R04: registered, fires the cycle after the edge
    trig_nxt = |(rise & sel_r);

    src_nxt = src_r;
    // R09: flags show asserted functions
    src_nxt[`AIS_SRC_DET_LSB +: 4] = det_src_nxt;
    src_nxt[1] = 1'b0;
    // R11: cleared only after all MSB reads
    msb_nxt = msb_r;
    if (nd_rise)
    begin
      src_nxt[`AIS_NEW_SAMPLE_EVENT_BIT_BIT] = 1'b1;
      msb_nxt = 3'h0;
    end
    else if (src_r[`AIS_NEW_SAMPLE_EVENT_BIT_BIT])
    begin
      msb_nxt = msb_r | axis_msb_rd;
      if (msb_nxt == `AIS_MSB_ALL)
      begin
        src_nxt[`AIS_NEW_SAMPLE_EVENT_BIT_BIT] = 1'b0;
        msb_nxt = 3'h0;
      end
    end
    // R15: buffer event bit
    if (buf_set)
      src_nxt[`AIS_SRC_BUF_BIT] = 1'b1;
    else if (buf_status_rd)
      src_nxt[`AIS_SRC_BUF_BIT] = 1'b0;
    // R12: mode change sets bit 7
    // R14: mode register read clears it
    if (mif.chg_p)
      src_nxt[`AIS_AUTOSLEEP_EVENT_BIT_BIT] = 1'b1;
    else if (system_mode_state_rd)
      src_nxt[`AIS_AUTOSLEEP_EVENT_BIT_BIT] = 1'b0;

    // R07: gate error, set wins over empty
    gerr_nxt = gerr_r;
    if (gate_err_det)
      gerr_nxt = 1'b1;
    else if (buf_empty)
      gerr_nxt = 1'b0;
    // R08: elapsed periods, saturating
    fgt_nxt = fgt_r;
    if (!gerr_nxt)
      fgt_nxt = `AIS_FGT_RST;
    else if (gerr_r && odr_tick && fgt_r != `AIS_FGT_MAX)
      fgt_nxt = fgt_r + 1'b1;

    rdata_nxt = rdata_r;
    if (reg_rd)
    begin
      case (reg_addr)
        `AIS_TRIG_OFS:
          rdata_nxt = {2'h0, tstat_r, 2'h0};
        // R05: mode code in low bits
        `AIS_SYSTEM_MODE_STATE_OFS:
          rdata_nxt = {gerr_r, fgt_r, mif.mode};
        `AIS_SRC_OFS:
          rdata_nxt = src_r;
        default:
          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_r <= `AIS_TRIG_RST;
      tstat_r <= 4'h0;
      prev_r <= 4'h0;
      src_r <= `AIS_SRC_RST;
      msb_r <= 3'h0;
      nd_prev_r <= 1'b0;
      bc_prev_r <= 1'b0;
      gerr_r <= 1'b0;
      fgt_r <= `AIS_FGT_RST;
      trig_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      sel_r <= sel_nxt;
      tstat_r <= tstat_nxt;
      prev_r <= det_irq;
      src_r <= src_nxt;
      msb_r <= msb_nxt;
      nd_prev_r <= axes_new_data_flag && drdy_int_en;
      bc_prev_r <= buf_cond;
      gerr_r <= gerr_nxt;
      fgt_r <= fgt_nxt;
      trig_r <= trig_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ais_mode_ctrl #(
    .CNT_W(CNT_W)
  ) u_mode (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .active_en(active_en),
    .autosleep_en(autosleep_en),
    .odr_tick(odr_tick),
    .activity(|(rise & det_int_en)),
    .wake_event(|(rise & wake_sel)),
    .inactivity_limit(inactivity_limit),
    .mif(mif.ctrl)
  );

  assign reg_rdata = rdata_r;
  assign buffer_trigger = trig_r;
  // R13: high rate while awake
  assign high_rate_sel = !mif.low_rate;
  assign sys_mode = mif.mode;

  sequence s_trans_rise;
    !det_irq[3] ##1 det_irq[3] && sel_r[3];
  endsequence

  sequence s_msb_done;
    src_r[0] && !nd_rise && ((msb_r | axis_msb_rd) == 3'h7);
  endsequence

  a_trig_sel_wr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    trig_wr |=> sel_r == $past(reg_wdata[5:2])) // R01
    else $error("trigger select not written");

  a_trig_edge_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_trans_rise |=> tstat_r[3] && buffer_trigger) // R02
    else $error("trigger status missed rising edge");

  a_trig_no_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
    det_irq[2] && prev_r[2] && det_src_rd[2] |=> !tstat_r[2] && !buffer_trigger) // R03
    else $error("trigger status set by steady level");

  a_trig_pulse_src: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(|(rise & sel_r)) |=> !buffer_trigger) // R04
    else $error("buffer trigger without selected edge");

  a_mode_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == 8'h0b |=> reg_rdata[1:0] == $past(sys_mode)
      && reg_rdata[1:0] != 2'h3) // R05
    else $error("mode field read wrong");

  a_gerr_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    buf_empty && !gate_err_det |=> !gerr_r ##0 fgt_r == 5'h00) // R07
    else $error("gate error not cleared by empty buffer");

  a_fgt_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    gerr_r && odr_tick && !buf_empty && fgt_r < 5'h1f |=> fgt_r == $past(fgt_r) + 5'h01) // R08
    else $error("gate elapsed count did not advance");

  a_drdy_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    src_r[0] && (nd_rise || (msb_r | axis_msb_rd) != 3'h7) |=> src_r[0]) // R11
    else $error("new data bit cleared early");

  a_drdy_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_msb_done |=> !src_r[0]) // R11
    else $error("new data bit not cleared");

  a_aslp_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    system_mode_state_rd && !mif.chg_p |=> !src_r[7]) // R14
    else $error("mode read did not clear bit 7");

  a_buf_rearm: assert property (@(posedge clk_sys) disable iff (!rst_n)
    buf_status_rd ##1 buf_cond && buf_sample_push |=> src_r[6]) // R16
    else $error("buffer bit not set again on new sample");

  a_transient_source_register: assert property (@(posedge clk_sys) disable iff (!rst_n)
    det_src_rd[3] && !rise[3] |=> !src_r[5]) // R17
    else $error("transient bit not cleared by its read");

  a_buf_set_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
    buf_int_en && (buf_ovf || buf_wmrk) && !bc_prev_r |=> src_r[6]) // R15
    else $error("buffer bit not set on buffer event");

  a_buf_rd_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    buf_status_rd && !buf_sample_push && bc_prev_r |=> !src_r[6]) // R15
    else $error("buffer bit not cleared by status read");

  a_src_edge_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    det_irq[1] && !prev_r[1] && det_int_en[1] |=> src_r[3]) // R10
    else $error("tap source bit missed rising edge");

  a_aslp_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mif.chg_p |=> src_r[7]) // R12
    else $error("mode change did not set bit 7");

  a_trig_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    det_irq[0] && prev_r[0] && !tstat_r[0] |=> !tstat_r[0]) // R02
    else $error("steady level set trigger status");
endmodule
`default_nettype wire

//--- ais_int_status_bench.sv
/*
  Self-checking bench of the interrupt status block.
  Assumes ais_host_model stands in for the host on the register port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ais_params.svh"
module ais_int_status_bench;
  import ais_pkg::*;
  logic clk_sys, rst_n, active_en, autosleep_en, odr_tick, axes_new_data_flag;
  logic drdy_int_en, buf_ovf, buf_wmrk, buf_int_en, buf_sample_push, buf_empty;
  logic gate_err_det, reg_wr, reg_rd, buf_status_rd, buffer_trigger, high_rate_sel;
  logic [3:0] det_irq, det_int_en, wake_sel, det_src_rd;
  logic [2:0] axis_msb_rd;
  logic [1:0] sys_mode;
  logic [7:0] inactivity_limit, reg_addr, reg_wdata, reg_rdata, q;
  int bad_count = 0;
  int checks = 0;
  int i, n, lim, seed;

  ais_int_status #(.CNT_W(8)) i_ais_int_status (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .det_irq(det_irq), .det_int_en(det_int_en),
    .det_src_rd(det_src_rd), .wake_sel(wake_sel), .active_en(active_en),
    .autosleep_en(autosleep_en), .inactivity_limit(inactivity_limit),
    .odr_tick(odr_tick), .axes_new_data_flag(axes_new_data_flag),
    .drdy_int_en(drdy_int_en), .axis_msb_rd(axis_msb_rd), .buf_ovf(buf_ovf),
    .buf_wmrk(buf_wmrk), .buf_int_en(buf_int_en), .buf_sample_push(buf_sample_push),
    .buf_status_rd(buf_status_rd), .buf_empty(buf_empty), .gate_err_det(gate_err_det),
    .buffer_trigger(buffer_trigger), .high_rate_sel(high_rate_sel), .sys_mode(sys_mode));

  ais_host_model i_ais_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .det_src_rd(det_src_rd), .axis_msb_rd(axis_msb_rd), .buf_status_rd(buf_status_rd));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (bad_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [7:0] exp_sys(input logic ge, input int c, input logic [1:0] m);
    return {ge, (c > 31) ? `AIS_FGT_MAX : 5'(c), m};
  endfunction

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic tick(input int k);
    repeat (k)
    begin
      odr_tick = 1'b1;
      cyc(1);
      odr_tick = 1'b0;
      cyc(2);
    end
  endtask

  task automatic rd(input logic [7:0] a);
    i_ais_host_model.acc(1'b0, a, 8'h00, q);
  endtask

  initial
  begin
    #(40 * 8000);
    bad_count++;
    end_sim();
  end

  initial
  begin
    {det_irq, det_int_en, wake_sel, inactivity_limit} = 20'h00000;
    {active_en, autosleep_en, odr_tick, axes_new_data_flag, drdy_int_en} = 5'h00;
    {buf_ovf, buf_wmrk, buf_int_en, buf_sample_push, buf_empty, gate_err_det} = 6'h00;
    rst_n = 1'b0;
    seed = $urandom(32'h857b);
    repeat (5) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    chk({6'h00, sys_mode}, 8'h00);
    chk({7'h00, high_rate_sel}, 8'h01);
    for (int a = 8'h0a; a < 8'h0e; a++)
    begin
      rd(8'(a));
      chk(q, 8'h00);
    end
    det_int_en = 4'hf;
    n = $urandom_range(3, 0);
    for (int k = 0; k < 4; k++)
    begin
      i = (k + n) % 4;
      i_ais_host_model.acc(1'b1, `AIS_TRIG_OFS, 8'h04 << i, q);
      det_irq[i] = 1'b1;
      cyc(1);
      chk({7'h00, buffer_trigger}, 8'h01);
      cyc(1);
      chk({7'h00, buffer_trigger}, 8'h00);
      rd(`AIS_TRIG_OFS);
      chk(q, 8'h04 << i);
      rd(`AIS_SRC_OFS);
      chk(q, 8'h04 << i);
      i_ais_host_model.strobe(8'h01 << i);
      rd(`AIS_TRIG_OFS);
      chk(q, 8'h00);
      rd(`AIS_SRC_OFS);
      chk(q, 8'h00);
      det_irq[i] = 1'b0;
    end
    i_ais_host_model.acc(1'b1, `AIS_TRIG_OFS, 8'h00, q);
    det_int_en = 4'h7;
    det_irq[3] = 1'b1;
    cyc(1);
    chk({7'h00, buffer_trigger}, 8'h00);
    rd(`AIS_SRC_OFS);
    chk(q, 8'h00);
    det_irq[3] = 1'b0;
    {drdy_int_en, axes_new_data_flag} = 2'b11;
    cyc(2);
    rd(`AIS_SRC_OFS);
    chk(q, 8'h01);
    i_ais_host_model.strobe(8'h30);
    rd(`AIS_SRC_OFS);
    chk(q, 8'h01);
    i_ais_host_model.strobe(8'h40);
    axes_new_data_flag = 1'b0;
    rd(`AIS_SRC_OFS);
    chk(q, 8'h00);
    buf_int_en = 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      {buf_ovf, buf_wmrk} = 2'b01 << m;
      cyc(2);
      rd(`AIS_SRC_OFS);
      chk(q, 8'h40);
      i_ais_host_model.strobe(8'h80);
      rd(`AIS_SRC_OFS);
      chk(q, 8'h00);
      buf_sample_push = 1'b1;
      cyc(1);
      buf_sample_push = 1'b0;
      rd(`AIS_SRC_OFS);
      chk(q, 8'h40);
      i_ais_host_model.strobe(8'h80);
      buf_sample_push = 1'b1;
      cyc(1);
      buf_sample_push = 1'b0;
      rd(`AIS_SRC_OFS);
      chk(q, 8'h40);
      {buf_ovf, buf_wmrk} = 2'b00;
      i_ais_host_model.strobe(8'h80);
    end
    for (int g = 0; g < 2; g++)
    begin
      n = (g == 0) ? 33 : $urandom_range(30, 1);
      gate_err_det = 1'b1;
      cyc(1);
      gate_err_det = 1'b0;
      tick(n);
      rd(`AIS_SYSTEM_MODE_STATE_OFS);
      chk(q, exp_sys(1'b1, n, `AIS_MODE_STANDBY));
      buf_empty = 1'b1;
      cyc(2);
      buf_empty = 1'b0;
      rd(`AIS_SYSTEM_MODE_STATE_OFS);
      chk(q, exp_sys(1'b0, 0, `AIS_MODE_STANDBY));
    end
    lim = $urandom_range(6, 2);
    inactivity_limit = 8'(lim);
    {active_en, autosleep_en} = 2'b11;
    cyc(2);
    chk({6'h00, sys_mode}, {6'h00, `AIS_MODE_WAKE});
    tick(lim);
    chk({6'h00, sys_mode}, {6'h00, `AIS_MODE_WAKE});
    tick(1);
    chk({6'h00, sys_mode}, {6'h00, `AIS_MODE_SLEEP});
    chk({7'h00, high_rate_sel}, 8'h00);
    rd(`AIS_SRC_OFS);
    chk(q, 8'h80);
    i_ais_host_model.poll_mode(q);
    chk(q, exp_sys(1'b0, 0, `AIS_MODE_SLEEP));
    rd(`AIS_SRC_OFS);
    chk(q, 8'h00);
    wake_sel = 4'h1;
    det_irq[0] = 1'b1;
    cyc(2);
    chk({6'h00, sys_mode}, {6'h00, `AIS_MODE_WAKE});
    chk({7'h00, high_rate_sel}, 8'h01);
    rd(`AIS_SRC_OFS);
    chk(q, 8'h84);
    active_en = 1'b0;
    cyc(2);
    chk({6'h00, sys_mode}, {6'h00, `AIS_MODE_STANDBY});
    end_sim();
  end
endmodule
`default_nettype wire

//--- ais_mode_ctrl.sv
/*
  Standby / wake / sleep controller with the inactivity counter.
  Assumes odr_tick is a one-cycle enable at the sample rate.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ais_params.svh"
module ais_mode_ctrl
  import ais_pkg::*;
#(
  parameter int CNT_W = 8
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic active_en,
  input wire logic autosleep_en,
  input wire logic odr_tick,
  input wire logic activity,
  input wire logic wake_event,
  input wire logic [CNT_W-1:0] inactivity_limit,
  ais_mode_if.ctrl mif
);
  ais_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic chg_r, chg_nxt;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    chg_nxt = 1'b0;
    case (state_r)
      AIS_ST_STANDBY:
      begin
        cnt_nxt = '0;
        if (active_en)
          state_nxt = AIS_ST_WAKE;
      end
      AIS_ST_WAKE:
      begin
        if (!active_en)
          state_nxt = AIS_ST_STANDBY;
        else if (activity || !autosleep_en)
          cnt_nxt = '0;
        // R12: inactivity past limit
        else if (odr_tick && cnt_r >= inactivity_limit)
        begin
          state_nxt = AIS_ST_SLEEP;
          cnt_nxt = '0;
          chg_nxt = 1'b1;
        end
        else if (odr_tick)
          cnt_nxt = cnt_r + 1'b1;
      end
      AIS_ST_SLEEP:
      begin
        if (!active_en)
          state_nxt = AIS_ST_STANDBY;
        // R13: wake event
        else if (wake_event)
        begin
          state_nxt = AIS_ST_WAKE;
          chg_nxt = 1'b1;
        end
      end
      default:
        state_nxt = AIS_ST_STANDBY;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= AIS_ST_STANDBY;
      cnt_r <= '0;
      chg_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      chg_r <= chg_nxt;
    end
  end

  assign mif.mode = (state_r == AIS_ST_WAKE) ? `AIS_MODE_WAKE :
                    (state_r == AIS_ST_SLEEP) ? `AIS_MODE_SLEEP : `AIS_MODE_STANDBY;
  assign mif.chg_p = chg_r;
  assign mif.low_rate = (state_r == AIS_ST_SLEEP);

  sequence s_idle_expire;
    state_r == AIS_ST_WAKE && active_en && autosleep_en && !activity
      && odr_tick && cnt_r >= inactivity_limit;
  endsequence

  a_sleep_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_idle_expire |=> state_r == AIS_ST_SLEEP && chg_r && mif.low_rate) // R12
    else $error("sleep not entered after inactivity");

  a_wake_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == AIS_ST_SLEEP && active_en && wake_event
      |=> mif.mode == `AIS_MODE_WAKE && chg_r ##1 !chg_r) // R13
    else $error("wake not entered on wake event");
endmodule
`default_nettype wire

//--- ais_mode_if.sv
/*
  Carrier from the mode controller to the status block.
  Assumes both ends share clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
interface ais_mode_if;
  import ais_pkg::*;
  ais_mode_t mode;
  logic chg_p;
  logic low_rate;
  modport ctrl (output mode, output chg_p, output low_rate);
  modport stat (input mode, input chg_p, input low_rate);
endinterface
`default_nettype wire

//--- ais_params.svh
/*
  Register offsets, field positions, reset values and mode codes
  of the interrupt status and buffer trigger block.
  Assumes nothing; definitions only.
*/
`ifndef AIS_PARAMS_SVH
`define AIS_PARAMS_SVH

`define AIS_TRIG_OFS 8'h0a
`define AIS_SYSTEM_MODE_STATE_OFS 8'h0b
`define AIS_SRC_OFS 8'h0c

`define AIS_TRIG_LSB 2
`define AIS_NEW_SAMPLE_EVENT_BIT_BIT 0
`define AIS_SRC_DET_LSB 2
`define AIS_SRC_BUF_BIT 6
`define AIS_AUTOSLEEP_EVENT_BIT_BIT 7
`define AIS_GERR_BIT 7
`define AIS_FGT_LSB 2

`define AIS_TRIG_RST 4'h0
`define AIS_SRC_RST 8'h00
`define AIS_FGT_RST 5'h00
`define AIS_FGT_MAX 5'h1f
`define AIS_MSB_ALL 3'h7

`define AIS_MODE_STANDBY 2'h0
`define AIS_MODE_WAKE 2'h1
`define AIS_MODE_SLEEP 2'h2

`endif

//--- ais_pkg.sv
/*
  Types shared by the interrupt status block and its mode controller.
  Assumes ais_params.svh for numeric codes.
*/
`default_nettype none
package ais_pkg;
  typedef enum logic [1:0] {AIS_ST_STANDBY, AIS_ST_WAKE, AIS_ST_SLEEP} ais_state_t;
  typedef logic [1:0] ais_mode_t;
  typedef logic [7:0] ais_byte_t;
endpackage
`default_nettype wire
